// ===== core/ccppwm_regs.vh
// Register map, field positions, reset values and timing for the PWM unit.
// Assumes an AXI4-Lite slave with 32-bit data; offsets are word indices, byte address is 4x.
`ifndef CCPPWM_REGS_VH
`define CCPPWM_REGS_VH

`define CCPPWM_OFF_UNIT_CONTROL     4'h0
`define CCPPWM_OFF_DUTY_HIGH_WRITE  4'h1
`define CCPPWM_OFF_DUTY_HIGH_ACTIVE 4'h2
`define CCPPWM_OFF_PERIOD_LIMIT     4'h3
`define CCPPWM_OFF_TIMER_CONTROL    4'h4
`define CCPPWM_OFF_TIMER_COUNT      4'h5
`define CCPPWM_OFF_IRQ_STATUS       4'h6
`define CCPPWM_OFF_IRQ_MASK         4'h7
`define CCPPWM_OFF_MISC_CONTROL     4'h8

`define CCPPWM_UC_MODE_LSB          0
`define CCPPWM_UC_LOW_LSB           4
`define CCPPWM_TC_PRESCALE_LSB      0
`define CCPPWM_TC_RUN_BIT           2
`define CCPPWM_MC_SLEEP_BIT         0
`define CCPPWM_MC_DIR_BIT           1

`define CCPPWM_RST_UNIT_CONTROL     6'h00
`define CCPPWM_RST_PERIOD_LIMIT     8'hFF
`define CCPPWM_RST_DIR              1'b1

`define CCPPWM_PHASE_STEPS          4

`endif

// ===== core/ccppwm_axil.v
// AXI4-Lite slave front end: one write and one read at a time.
// Assumes the master keeps valid and payload steady until taken.
`timescale 1ns/100ps
module ccppwm_axil (
  input  wire        clk,
  input  wire        resetn,
  input  wire [31:0] s_awaddr,
  input  wire        s_awvalid,
  output wire        s_awready,
  input  wire [31:0] s_wdata,
  input  wire [3:0]  s_wstrb,
  input  wire        s_wvalid,
  output wire        s_wready,
  output reg  [1:0]  s_bresp,
  output reg         s_bvalid,
  input  wire        s_bready,
  input  wire [31:0] s_araddr,
  input  wire        s_arvalid,
  output wire        s_arready,
  output reg  [31:0] s_rdata,
  output reg  [1:0]  s_rresp,
  output reg         s_rvalid,
  input  wire        s_rready,
  output reg         wr_pulse,
  output reg  [3:0]  wr_index,
  output reg  [7:0]  wr_data,
  output reg         wr_ok,
  output wire        rd_pulse,
  output wire [3:0]  rd_index,
  input  wire [31:0] rd_data,
  input  wire        rd_ok
);
  reg        aw_have_reg;
  reg        w_have_reg;
  reg [31:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg        w_lane_reg;

  assign s_awready = !aw_have_reg && !s_bvalid;
  assign s_wready  = !w_have_reg && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign rd_pulse  = s_arvalid && s_arready;
  assign rd_index  = s_araddr[5:2];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_addr_reg <= 32'h0;
      w_data_reg  <= 32'h0;
      w_lane_reg  <= 1'b0;
      s_bvalid    <= 1'b0;
      s_bresp     <= 2'h0;
      s_rvalid    <= 1'b0;
      s_rresp     <= 2'h0;
      s_rdata     <= 32'h0;
      wr_pulse    <= 1'b0;
      wr_index    <= 4'h0;
      wr_data     <= 8'h00;
      wr_ok       <= 1'b0;
    end else begin
      wr_pulse <= 1'b0;
      if (s_awvalid && s_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_lane_reg <= s_wstrb[0];
      end
      if (aw_have_reg && w_have_reg) begin
        // Only the low byte carries data; a write without lane 0 changes nothing
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        wr_index    <= aw_addr_reg[5:2];
        wr_data     <= w_data_reg[7:0];
        wr_ok       <= (aw_addr_reg[31:6] == 26'h0) && (aw_addr_reg[5:2] <= 4'h8);
        wr_pulse    <= w_lane_reg && (aw_addr_reg[31:6] == 26'h0);
        s_bresp     <= ((aw_addr_reg[31:6] == 26'h0) && (aw_addr_reg[5:2] <= 4'h8))
                       ? 2'h0 : 2'h2;
        s_bvalid    <= 1'b1;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (rd_pulse) begin
        s_rvalid <= 1'b1;
        s_rdata  <= (rd_ok && s_araddr[31:6] == 26'h0) ? rd_data : 32'h0;
        s_rresp  <= (rd_ok && s_araddr[31:6] == 26'h0) ? 2'h0 : 2'h2;
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== core/ccppwm_top.v
// Standard PWM unit: period timer, prescaler, double-buffered 10-bit duty.
// Assumes a single 100 MHz clock; pin routing and port logic sit outside.
`timescale 1ns/100ps
`include "ccppwm_regs.vh"

// Overview of operation
// - Period is (period_limit+1) times four clocks times the prescale value.
// - After count equals limit: clear count, set pin unless duty zero, latch duty.
// - Duty is ten bits: eight from duty_high_write, two from duty_low_bits.
// - Duty writes accepted anytime; they take effect only at the next period match.
// - In PWM mode duty_high_active is readable but ignores writes.
// - Active duty held double-buffered in duty_high_active plus a hidden 2-bit latch.
// - Time base is count extended by phase counter or by prescaler bits.
// - Pin goes low when time base equals active duty.
// - No postscaler affects the period; only prescaler and period_limit.
// - If pulse width exceeds the period the pin is never cleared.
// - Resolution is log2 of 4 times (period_limit+1), ten bits at 255.
// - Sleep freezes counting, the duty latch and the pin level; register writes and mode 0000 still take effect.
// - period_match_flag sets on each rollover at a period match.
// - Mode bits 11xx select PWM regardless of the two low bits.
// - Mode 0000 turns the unit off and clears the duty latch and pin; the timer keeps counting.
module ccppwm_top (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire [31:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output wire        S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output wire        S_AXI_WREADY,
  output wire [1:0]  S_AXI_BRESP,
  output wire        S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [31:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output wire        S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0]  S_AXI_RRESP,
  output wire        S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        SLEEP,
  output wire        PWM_OUTPUT_PIN,
  output wire        PWM_OUTPUT_OE,
  output wire        IRQ
);
  wire        wr_pulse;
  wire [3:0]  wr_index;
  wire [7:0]  wr_data;
  wire        wr_ok;
  wire        rd_pulse;
  wire [3:0]  rd_index;
  reg  [31:0] rd_data;
  reg         rd_ok;

  reg  [5:0]  unit_control_reg;
  reg  [7:0]  duty_high_write_reg;
  reg  [7:0]  duty_high_active_reg;
  reg  [1:0]  duty_low_latch_reg;
  reg  [7:0]  period_limit_reg;
  reg  [2:0]  timer_control_reg;
  reg  [7:0]  period_timer_count_reg;
  reg  [3:0]  prescale_count_reg;
  reg  [1:0]  phase_reg;
  reg         pin_reg;
  reg         status_reg;
  reg         mask_reg;
  reg  [1:0]  misc_reg;

  wire        sleeping = SLEEP | misc_reg[`CCPPWM_MC_SLEEP_BIT];
  wire [3:0]  mode_sel = unit_control_reg[3:0];
  wire        pwm_mode = (mode_sel[3:2] == 2'b11);
  wire        unit_off = (mode_sel == 4'h0);
  wire [1:0]  prescale = timer_control_reg[1:0];
  wire        running  = timer_control_reg[`CCPPWM_TC_RUN_BIT];
  wire [9:0]  duty_next = {duty_high_write_reg, unit_control_reg[5:4]};
  wire [9:0]  duty_act  = {duty_high_active_reg, duty_low_latch_reg};

  // Prescale ratio minus one: 1:1, 1:4, 1:16, 1:16 on the two select bits
  function [5:0] ps_last;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   ps_last = 6'h00;
        2'b01:   ps_last = 6'h03;
        default: ps_last = 6'h0F;
      endcase
    end
  endfunction

  // A full prescaler of 16 keeps the top two of its four bits as extension
  function [1:0] ext_bits;
    input [1:0] sel;
    input [3:0] pc;
    input [1:0] ph;
    begin
      case (sel)
        2'b00:   ext_bits = ph;
        2'b01:   ext_bits = pc[1:0];
        default: ext_bits = pc[3:2];
      endcase
    end
  endfunction

  // The prescaler ticks once per four clocks; phase_reg supplies those clocks
  wire        phase_wrap = (phase_reg == 2'h3);
  // Greater-or-equal lets a prescale change mid-count wrap at once instead of running to 15
  wire        ps_wrap    = ({2'b00, prescale_count_reg} >= ps_last(prescale));
  wire        step_tmr   = running && !sleeping && phase_wrap && ps_wrap;
  // Edges at which the ten-bit time base moves on by one step
  wire        fine_step  = running && !sleeping &&
                           ((prescale == 2'b00) ? 1'b1 :
                            (prescale == 2'b01) ? phase_wrap :
                            (phase_wrap && prescale_count_reg[1:0] == 2'h3));
  wire        at_match   = (period_timer_count_reg == period_limit_reg);
  wire        rollover   = step_tmr && at_match;
  wire [9:0]  time_base  = {period_timer_count_reg,
                            ext_bits(prescale, prescale_count_reg, phase_reg)};

  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      phase_reg              <= 2'h0;
      prescale_count_reg     <= 4'h0;
      period_timer_count_reg <= 8'h00;
    end else if (running && !sleeping) begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_wrap) begin
        if (ps_wrap) begin
          prescale_count_reg <= 4'h0;
          period_timer_count_reg <= at_match ? 8'h00 : period_timer_count_reg + 8'h01;
        end else begin
          prescale_count_reg <= prescale_count_reg + 4'h1;
        end
      end
    end
  end

  // Duty latch and pin; set at rollover, cleared on the exact ten-bit match
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      duty_high_active_reg <= 8'h00;
      duty_low_latch_reg   <= 2'h0;
      pin_reg              <= 1'b0;
    end else if (unit_off) begin
      duty_high_active_reg <= 8'h00;
      duty_low_latch_reg   <= 2'h0;
      pin_reg              <= 1'b0;
    end else if (pwm_mode && !sleeping) begin
      if (rollover) begin
        duty_high_active_reg <= duty_next[9:2];
        duty_low_latch_reg   <= duty_next[1:0];
        pin_reg              <= (duty_next != 10'h000);
      end else if (fine_step && (time_base + 10'h001) == duty_act) begin
        // Clear on the step that reaches the duty, so the high time is exactly duty steps
        // Duty beyond the period never matches, so the pin stays put
        pin_reg <= 1'b0;
      end
    end
  end

  // Register writes; hardware set of the flag wins over a clearing read
  always @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      unit_control_reg    <= `CCPPWM_RST_UNIT_CONTROL;
      duty_high_write_reg <= 8'h00;
      period_limit_reg    <= `CCPPWM_RST_PERIOD_LIMIT;
      timer_control_reg   <= 3'h0;
      status_reg          <= 1'b0;
      mask_reg            <= 1'b0;
      misc_reg            <= {`CCPPWM_RST_DIR, 1'b0};
    end else begin
      if (wr_pulse && wr_ok) begin
        case (wr_index)
          `CCPPWM_OFF_UNIT_CONTROL:    unit_control_reg    <= wr_data[5:0];
          `CCPPWM_OFF_DUTY_HIGH_WRITE: duty_high_write_reg <= wr_data;
          `CCPPWM_OFF_PERIOD_LIMIT:    period_limit_reg    <= wr_data;
          `CCPPWM_OFF_TIMER_CONTROL:   timer_control_reg   <= wr_data[2:0];
          `CCPPWM_OFF_IRQ_MASK:        mask_reg            <= wr_data[0];
          `CCPPWM_OFF_MISC_CONTROL:    misc_reg            <= wr_data[1:0];
          default: ;
        endcase
      end
      if (rollover)
        status_reg <= 1'b1;
      else if (rd_pulse && rd_index == `CCPPWM_OFF_IRQ_STATUS &&
               S_AXI_ARADDR[31:6] == 26'h0)
        status_reg <= 1'b0;
    end
  end

  always @* begin
    rd_ok   = 1'b1;
    rd_data = 32'h0;
    case (rd_index)
      `CCPPWM_OFF_UNIT_CONTROL:     rd_data = {26'h0, unit_control_reg};
      `CCPPWM_OFF_DUTY_HIGH_WRITE:  rd_data = {24'h0, duty_high_write_reg};
      `CCPPWM_OFF_DUTY_HIGH_ACTIVE: rd_data = {24'h0, duty_high_active_reg};
      `CCPPWM_OFF_PERIOD_LIMIT:     rd_data = {24'h0, period_limit_reg};
      `CCPPWM_OFF_TIMER_CONTROL:    rd_data = {29'h0, timer_control_reg};
      `CCPPWM_OFF_TIMER_COUNT:      rd_data = {24'h0, period_timer_count_reg};
      `CCPPWM_OFF_IRQ_STATUS:       rd_data = {31'h0, status_reg};
      `CCPPWM_OFF_IRQ_MASK:         rd_data = {31'h0, mask_reg};
      `CCPPWM_OFF_MISC_CONTROL:     rd_data = {30'h0, misc_reg};
      default:                      rd_ok   = 1'b0;
    endcase
  end

  assign PWM_OUTPUT_PIN = pin_reg;
  // Driver enabled only once software clears the direction bit
  assign PWM_OUTPUT_OE  = pwm_mode && !misc_reg[`CCPPWM_MC_DIR_BIT];
  assign IRQ            = status_reg & mask_reg;

  ccppwm_axil u_axil (
    .clk       (CLK),
    .resetn    (RESETN),
    .s_awaddr  (S_AXI_AWADDR),
    .s_awvalid (S_AXI_AWVALID),
    .s_awready (S_AXI_AWREADY),
    .s_wdata   (S_AXI_WDATA),
    .s_wstrb   (S_AXI_WSTRB),
    .s_wvalid  (S_AXI_WVALID),
    .s_wready  (S_AXI_WREADY),
    .s_bresp   (S_AXI_BRESP),
    .s_bvalid  (S_AXI_BVALID),
    .s_bready  (S_AXI_BREADY),
    .s_araddr  (S_AXI_ARADDR),
    .s_arvalid (S_AXI_ARVALID),
    .s_arready (S_AXI_ARREADY),
    .s_rdata   (S_AXI_RDATA),
    .s_rresp   (S_AXI_RRESP),
    .s_rvalid  (S_AXI_RVALID),
    .s_rready  (S_AXI_RREADY),
    .wr_pulse  (wr_pulse),
    .wr_index  (wr_index),
    .wr_data   (wr_data),
    .wr_ok     (wr_ok),
    .rd_pulse  (rd_pulse),
    .rd_index  (rd_index),
    .rd_data   (rd_data),
    .rd_ok     (rd_ok)
  );
endmodule

// ===== dv/ccppwm_chk.sv
// Port checks for the PWM unit: bus handshake timing and sleep hold.
// Bound to ccppwm_top; one clock, asynchronous active-low reset.
`timescale 1ns/100ps
module ccppwm_chk (
  input wire        CLK,
  input wire        RESETN,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_BREADY,
  input wire [31:0] S_AXI_ARADDR,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire        SLEEP,
  input wire        PWM_OUTPUT_PIN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence s_wr; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY; endsequence
  sequence s_rd; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  property p_wr_lat; s_wr |=> !S_AXI_BVALID ##1 S_AXI_BVALID; endproperty
  property p_rd_lat; s_rd |=> S_AXI_RVALID; endproperty
  property p_rd_bad; s_rd ##0 S_AXI_ARADDR >= 32'h40 |=> S_AXI_RRESP == 2'h2 && !S_AXI_RDATA;
  endproperty
  property p_b_done; S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID; endproperty
  property p_r_done; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID; endproperty
  property p_w_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
  property p_r_busy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  property p_sleep; SLEEP |=> $stable(PWM_OUTPUT_PIN); endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer late");
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
  a_rd_bad: assert property (p_rd_bad) else $error("unmapped read");
  a_b_done: assert property (p_b_done) else $error("write answer stuck");
  a_r_done: assert property (p_r_done) else $error("read answer stuck");
  a_w_busy: assert property (p_w_busy) else $error("write taken while busy");
  a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
  a_sleep: assert property (p_sleep) else $error("pin moved in sleep");
endmodule
bind ccppwm_top ccppwm_chk i_ccppwm_chk (
  .CLK           (CLK),
  .RESETN        (RESETN),
  .S_AXI_AWVALID (S_AXI_AWVALID),
  .S_AXI_AWREADY (S_AXI_AWREADY),
  .S_AXI_WVALID  (S_AXI_WVALID),
  .S_AXI_WREADY  (S_AXI_WREADY),
  .S_AXI_BVALID  (S_AXI_BVALID),
  .S_AXI_BREADY  (S_AXI_BREADY),
  .S_AXI_ARADDR  (S_AXI_ARADDR),
  .S_AXI_ARVALID (S_AXI_ARVALID),
  .S_AXI_ARREADY (S_AXI_ARREADY),
  .S_AXI_RDATA   (S_AXI_RDATA),
  .S_AXI_RRESP   (S_AXI_RRESP),
  .S_AXI_RVALID  (S_AXI_RVALID),
  .S_AXI_RREADY  (S_AXI_RREADY),
  .SLEEP         (SLEEP),
  .PWM_OUTPUT_PIN(PWM_OUTPUT_PIN)
);

// ===== dv/ccppwm_load.sv
// Load on the PWM pin: measures high time and period in clocks.
// Assumes a pull-down holds the node low while the driver is off.
`timescale 1ns/100ps
module ccppwm_load (
  input  wire        clk,
  input  wire        resetn,
  input  wire        pin,
  input  wire        oe,
  output reg  [31:0] hi,
  output reg  [31:0] per,
  output reg  [31:0] rises
);
  reg  [31:0] hi_cnt;
  reg  [31:0] per_cnt;
  reg         line_q;
  wire        line = oe ? pin : 1'h0;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hi <= 32'h0;
      per <= 32'h0;
      rises <= 32'h0;
      hi_cnt <= 32'h0;
      per_cnt <= 32'h0;
      line_q <= 1'h0;
    end else begin
      line_q <= line;
      per_cnt <= per_cnt + 32'h1;
      hi_cnt <= hi_cnt + {31'h0, line};
      if (line && !line_q) begin
        per <= per_cnt;
        hi <= hi_cnt;
        rises <= rises + 32'h1;
        per_cnt <= 32'h1;
        hi_cnt <= 32'h1;
      end
    end
  end
endmodule

// ===== dv/tb.sv
// Bench for the PWM unit: register bus, waveform timing, sleep, mode off.
// Assumes the load model reports high time and period of each pulse.
`timescale 1ns/100ps
module tb;
  reg         CLK, RESETN, awv, wv, bre, arv, rre, slp;
  reg  [31:0] aw, wd, a, b;
  wire [31:0] rdat, hi, per, rises;
  wire [1:0]  bresp, rresp;
  wire        awr, wrdy, bv, arr, rv, pin, oe, irq;
  integer     error_cnt, compares, i;
  ccppwm_top i_ccppwm_top (.CLK(CLK), .RESETN(RESETN), .S_AXI_AWADDR(aw),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bre), .S_AXI_ARADDR(aw), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
    .SLEEP(slp), .PWM_OUTPUT_PIN(pin), .PWM_OUTPUT_OE(oe), .IRQ(irq));
  ccppwm_load i_ccppwm_load (.clk(CLK), .resetn(RESETN), .pin(pin), .oe(oe),
    .hi(hi), .per(per), .rises(rises));
  initial begin
    CLK = 1'h0;
    forever #5 CLK = ~CLK;
  end
  task summarize;
    begin
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0s expected %0h seen %0h", nm, e, g);
      end
    end
  endtask
  task tmo;
    begin
      chk("wait done", 1, 0);
      summarize;
    end
  endtask
  // One transfer; readies are sampled mid-cycle, where they equal the edge value
  task bus(input w, input [31:0] ad, input [31:0] d, output [31:0] q, output [1:0] r);
    integer n;
    reg ta, tw, tr, dn;
    begin
      @(posedge CLK);
      aw <= ad;
      wd <= d;
      awv <= w;
      wv <= w;
      bre <= w;
      arv <= !w;
      rre <= !w;
      n = 0;
      dn = 1'h0;
      while (!dn && n < 100) begin
        @(negedge CLK);
        ta = awv && awr;
        tw = wv && wrdy;
        tr = arv && arr;
        dn = w ? bv : rv;
        r = w ? bresp : rresp;
        q = rdat;
        n = n + 1;
        @(posedge CLK);
        if (ta) awv <= 1'h0;
        if (tw) wv <= 1'h0;
        if (tr) arv <= 1'h0;
        if (dn) bre <= 1'h0;
        if (dn) rre <= 1'h0;
      end
      if (!dn) tmo;
    end
  endtask
  task wr(input [31:0] ad, input [31:0] d);
    reg [1:0] r;
    begin
      bus(1'h1, ad, d, a, r);
      chk("bresp", 0, r);
    end
  endtask
  task rchk(input [31:0] ad, input [31:0] e);
    reg [1:0] r;
    begin
      bus(1'h0, ad, 0, a, r);
      chk("rresp", 0, r);
      chk("rdata", e, a);
    end
  endtask
  task periods(input integer k);
    integer n, r0;
    begin
      r0 = rises;
      n = 0;
      while (rises < r0 + k && n < 3000) begin
        @(posedge CLK);
        n = n + 1;
      end
      if (n >= 3000) tmo;
    end
  endtask
  task hold(input e);
    reg bad;
    begin
      bad = 1'h0;
      repeat (40) @(posedge CLK);
      repeat (16) begin
        @(negedge CLK);
        if (pin !== e) bad = 1'h1;
      end
      chk("level", 0, bad);
    end
  endtask
  task t_reset;
    begin
      rchk(32'h00, 32'h0);
      rchk(32'h0C, 32'hFF);
      rchk(32'h20, 32'h2);
    end
  endtask
  task t_setup;
    begin
      wr(32'h0C, 32'h3);
      wr(32'h00, 32'h2C);
      wr(32'h04, 32'h1);
      rchk(32'h18, 32'h0);
      wr(32'h1C, 32'h1);
      wr(32'h10, 32'h4);
      for (i = 0; i < 200 && irq !== 1'h1; i = i + 1) @(negedge CLK);
      chk("irq", 1, irq);
      if (i >= 200) tmo;
      rchk(32'h18, 32'h1);
      wr(32'h1C, 32'h0);
      @(negedge CLK);
      chk("irq masked", 0, irq);
      wr(32'h20, 32'h0);
      @(negedge CLK);
      chk("oe", 1, oe);
      for (i = 12; i < 16; i = i + 1) begin
        wr(32'h00, 32'h20 + i);
        periods(3);
        chk("period", 16, per);
        chk("high", 6, hi);
      end
    end
  endtask
  task t_buffer;
    begin
      periods(1);
      wr(32'h04, 32'h3);
      rchk(32'h08, 32'h1);
      periods(3);
      chk("high", 14, hi);
      for (i = 1; i < 3; i = i + 1) begin
        wr(32'h10, 32'h4 + i);
        periods(3);
        chk("period", 16 << (2 * i), per);
        chk("high", 14 << (2 * i), hi);
      end
      wr(32'h08, 32'h55);
      rchk(32'h08, 32'h3);
      wr(32'h10, 32'h4);
    end
  endtask
  task t_levels;
    begin
      wr(32'h04, 32'hFF);
      hold(1'h1);
      wr(32'h04, 32'h0);
      wr(32'h00, 32'h0C);
      hold(1'h0);
    end
  endtask
  task t_sleep;
    begin
      wr(32'h04, 32'h1);
      periods(2);
      slp <= 1'h1;
      rchk(32'h14, 32'h0);
      b = a;
      rchk(32'h14, b);
      slp <= 1'h0;
      periods(2);
      chk("high", 4, hi);
    end
  endtask
  task t_off;
    reg [1:0] r;
    begin
      bus(1'h1, 32'h40, 32'h1, a, r);
      chk("bresp bad", 2, r);
      bus(1'h0, 32'h40, 32'h0, a, r);
      chk("rresp bad", 2, r);
      chk("rdata bad", 0, a);
      wr(32'h00, 32'h0);
      @(posedge CLK);
      @(negedge CLK);
      chk("pin off", 0, pin);
      rchk(32'h08, 32'h0);
    end
  endtask
  initial begin
    {RESETN, awv, wv, bre, arv, rre, slp} = 7'h0;
    {aw, wd, a, b} = 128'h0;
    error_cnt = 0;
    compares = 0;
    repeat (5) @(posedge CLK);
    RESETN <= 1'h1;
    t_reset;
    t_setup;
    t_buffer;
    t_levels;
    t_sleep;
    t_off;
    summarize;
  end
endmodule
